// ===== design/port_a_io.sv
// port a io block: data, direction, pulls, input enable, two pin interrupts
// assumes a core io bus with one-cycle rd/wr strobes and external pad cells
`timescale 1ns/100ps
`default_nettype none
module port_a_io (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst,
  // core io bus
  input  wire gpio_pkg::io_req_t io_req,
  output logic [7:0]             io_rdata,
  // pads
  input  wire logic [7:0]        port_a_pin_in,
  input  wire logic              port_b_pin0,
  input  wire logic              port_b_pin5,
  output gpio_pkg::pad_ctl_t     pad_ctl,
  output logic [7:0]             port_a_input,
  output logic [7:0]             wake_ff,
  // interrupts
  output logic [1:0]             int_req_ff
);
  logic [7:0] data_ff;
  logic [7:0] dir_ff;
  logic [7:0] pull_up_ff;
  logic [7:0] pull_dn_ff;
  logic [7:0] in_en_ff;
  logic [3:0] edge_sel_ff;
  logic [1:0] flag_ff;
  logic [1:0] irq_en_ff;
  logic [7:0] pin_meta_ff;
  logic [7:0] pin_sync_ff;
  logic [7:0] pin_last_ff;
  logic [1:0] pb_meta_ff;
  logic [1:0] pb_sync_ff;
  logic [7:0] rdata_ff;
  logic [7:0] in_ff;
  gpio_pkg::pad_ctl_t pad_ff;
  logic [1:0] hit;
  logic [1:0] src_pin;
  logic [1:0] src_gate;
  logic [1:0] nxt_flag;
  logic [7:0] nxt_rdata;
  logic [7:0] toggled;
  logic       wr_data;
  logic       wr_dir;
  logic       wr_pull_up;
  logic       wr_pull_dn;
  logic       wr_in_en;
  logic       wr_edge_sel;
  logic       wr_irq_en;
  logic       wr_irq_req;

  function automatic logic wr_at(input gpio_pkg::io_req_t r,
                                 input logic [7:0] a);
    wr_at = r.wr & (r.addr == a);
  endfunction

  // shared sources: either pin of a pair can trigger, gated pins drop out;
  // only synchronised levels are combined, so no glitch reaches a detector
  assign src_pin[gpio_pkg::src_a0_pos] =
    (pin_sync_ff[gpio_pkg::pin0_pos] & in_en_ff[gpio_pkg::pin0_pos])
    | pb_sync_ff[gpio_pkg::src_a0_pos];
  assign src_pin[gpio_pkg::src_a4_pos] =
    (pin_sync_ff[gpio_pkg::pin4_pos] & in_en_ff[gpio_pkg::pin4_pos])
    | pb_sync_ff[gpio_pkg::src_a4_pos];
  assign src_gate = 2'h3;

  edge_detect u_edge_a0 (
    .clock (clock),
    .rst   (rst),
    .pin   (src_pin[gpio_pkg::src_a0_pos]),
    .gate  (src_gate[gpio_pkg::src_a0_pos]),
    .sel   (edge_sel_ff[gpio_pkg::sel_a0_lsb +: 2]),
    .hit   (hit[gpio_pkg::src_a0_pos])
  );

  edge_detect u_edge_a4 (
    .clock (clock),
    .rst   (rst),
    .pin   (src_pin[gpio_pkg::src_a4_pos]),
    .gate  (src_gate[gpio_pkg::src_a4_pos]),
    .sel   (edge_sel_ff[gpio_pkg::sel_a4_lsb +: 2]),
    .hit   (hit[gpio_pkg::src_a4_pos])
  );

  // write strobes, one per register
  assign wr_data     = wr_at(io_req, gpio_pkg::port_a_data_addr);
  assign wr_dir      = wr_at(io_req, gpio_pkg::port_a_dir_addr);
  assign wr_pull_up  = wr_at(io_req, gpio_pkg::port_a_pull_up_addr);
  assign wr_pull_dn  = wr_at(io_req, gpio_pkg::port_a_pull_dn_addr);
  assign wr_in_en    = wr_at(io_req, gpio_pkg::input_enable_addr);
  assign wr_edge_sel = wr_at(io_req, gpio_pkg::edge_select_addr);
  assign wr_irq_en   = wr_at(io_req, gpio_pkg::int_enable_addr);
  assign wr_irq_req  = wr_at(io_req, gpio_pkg::int_request_addr);

  // a set arriving with the clear wins so no edge is lost
  assign nxt_flag = wr_irq_req
                  ? ((flag_ff & io_req.wdata[1:0]) | hit)
                  : (flag_ff | hit);

  // edge select and input enable are write-only and read back as zero
  assign nxt_rdata =
      (io_req.addr == gpio_pkg::port_a_data_addr)    ? pin_sync_ff :
      (io_req.addr == gpio_pkg::port_a_dir_addr)     ? dir_ff :
      (io_req.addr == gpio_pkg::port_a_pull_up_addr) ? pull_up_ff :
      (io_req.addr == gpio_pkg::port_a_pull_dn_addr) ? pull_dn_ff :
      (io_req.addr == gpio_pkg::int_request_addr)    ? {6'h00, flag_ff} :
      (io_req.addr == gpio_pkg::int_enable_addr)     ? {6'h00, irq_en_ff} :
      8'h00;

  assign toggled = (pin_sync_ff ^ pin_last_ff) & in_en_ff;

  // synchronisers run through reset so the pin history is settled when
  // reset lifts; meta stages feed only the sync stages
  always_ff @(posedge clock) begin
    pin_meta_ff <= port_a_pin_in;
    pin_sync_ff <= pin_meta_ff;
    pin_last_ff <= pin_sync_ff;
    pb_meta_ff <= {port_b_pin0, port_b_pin5};
    pb_sync_ff <= pb_meta_ff;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      data_ff <= gpio_pkg::data_reset;
    end else if (wr_data) begin
      data_ff <= io_req.wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      dir_ff <= gpio_pkg::dir_reset;
    end else if (wr_dir) begin
      dir_ff <= io_req.wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pull_up_ff <= gpio_pkg::pull_reset;
    end else if (wr_pull_up) begin
      pull_up_ff <= io_req.wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pull_dn_ff <= gpio_pkg::pull_reset;
    end else if (wr_pull_dn) begin
      pull_dn_ff <= io_req.wdata;
    end
  end

  // reserved bits 2:1 are held zero whatever software writes
  always_ff @(posedge clock) begin
    if (rst) begin
      in_en_ff <= gpio_pkg::input_enable_reset;
    end else if (wr_in_en) begin
      in_en_ff <= io_req.wdata & gpio_pkg::input_enable_mask;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      edge_sel_ff <= gpio_pkg::edge_select_reset;
    end else if (wr_edge_sel) begin
      edge_sel_ff <= io_req.wdata[3:0];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      irq_en_ff <= gpio_pkg::irq_reset;
    end else if (wr_irq_en) begin
      irq_en_ff <= io_req.wdata[1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      flag_ff <= gpio_pkg::irq_reset;
      int_req_ff <= gpio_pkg::irq_reset;
    end else begin
      flag_ff <= nxt_flag;
      int_req_ff <= flag_ff & irq_en_ff;
    end
  end

  // registered copies for the pads and the read and input paths
  always_ff @(posedge clock) begin
    if (rst) begin
      wake_ff <= 8'h00;
      rdata_ff <= 8'h00;
      in_ff <= 8'h00;
      pad_ff <= '0;
    end else begin
      wake_ff <= toggled;
      rdata_ff <= io_req.rd ? nxt_rdata : 8'h00;
      in_ff <= pin_sync_ff & in_en_ff;
      pad_ff <= '{out: data_ff, oe: dir_ff, pull_up: pull_up_ff,
                  pull_dn: pull_dn_ff, in_en: in_en_ff};
    end
  end

  assign io_rdata = rdata_ff;
  assign port_a_input = in_ff;
  assign pad_ctl = pad_ff;
endmodule
`default_nettype wire

// ===== design/gpio_pkg.sv
// constants and carriers for the port a block with two pin interrupts
// assumes an 8-bit io bus from the core with single-cycle strobes
package gpio_pkg;
  localparam logic [7:0] edge_select_addr    = 8'h0c;
  localparam logic [7:0] input_enable_addr   = 8'h0d;
  localparam logic [7:0] port_a_data_addr    = 8'h10;
  localparam logic [7:0] port_a_dir_addr     = 8'h11;
  localparam logic [7:0] port_a_pull_up_addr = 8'h12;
  localparam logic [7:0] port_a_pull_dn_addr = 8'h13;
  // interrupt flag/enable bits live in the core's request/enable registers
  localparam logic [7:0] int_request_addr    = 8'h05;
  localparam logic [7:0] int_enable_addr     = 8'h04;

  localparam logic [7:0] data_reset          = 8'h00;
  localparam logic [7:0] dir_reset           = 8'h00;
  localparam logic [7:0] pull_reset          = 8'h00;
  localparam logic [7:0] input_enable_reset  = 8'hf9;
  localparam logic [7:0] input_enable_mask   = 8'hf9;
  localparam logic [3:0] edge_select_reset   = 4'h0;
  localparam logic [7:0] edge_select_mask    = 8'h0f;
  localparam logic [1:0] irq_reset           = 2'h0;

  // field positions
  localparam int pin0_pos   = 0;
  localparam int pin4_pos   = 4;
  localparam int src_a0_pos = 0;  // pin0 / port b pin5 source
  localparam int src_a4_pos = 1;  // pin4 / port b pin0 source
  localparam int sel_a0_lsb = 0;
  localparam int sel_a4_lsb = 2;

  localparam logic [1:0] edge_both    = 2'h0;
  localparam logic [1:0] edge_rising  = 2'h1;
  localparam logic [1:0] edge_falling = 2'h2;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } io_req_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pull_up;
    logic [7:0] pull_dn;
    logic [7:0] in_en;
  } pad_ctl_t;
endpackage

// ===== design/edge_detect.sv
// one interrupt source: edge qualifier on an already synchronised level
// assumes the pin input has passed two flops on clock before it arrives
`timescale 1ns/100ps
`default_nettype none
module edge_detect (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // source
  input  wire logic       pin,
  input  wire logic       gate,
  input  wire logic [1:0] sel,
  // event
  output logic            hit
);
  logic last_ff;
  logic rise;
  logic fall;

  // last_ff has no reset: it tracks a pin idling high through reset,
  // so no false edge appears when reset lifts
  always_ff @(posedge clock) begin
    last_ff <= pin;
  end

  assign rise = pin & ~last_ff;
  assign fall = ~pin & last_ff;

  // reserved select code 11 raises nothing; nothing is raised in reset
  assign hit = gate & ~rst
             & (((sel == gpio_pkg::edge_both) & (rise | fall))
             | ((sel == gpio_pkg::edge_rising) & rise)
             | ((sel == gpio_pkg::edge_falling) & fall));
endmodule
`default_nettype wire

// ===== sim/port_a_io_chk.sv
// port-level assertions for the port a block
// assumes one clock and a synchronous reset
`timescale 1ns/100ps
`default_nettype none
module port_a_io_chk (
  // clock and reset
  input wire logic               clock,
  input wire logic               rst,
  // watched ports
  input wire gpio_pkg::io_req_t  io_req,
  input wire logic [7:0]         io_rdata,
  input wire gpio_pkg::pad_ctl_t pad_ctl,
  input wire logic [1:0]         int_req_ff
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic irq_wr;
  // a flag or enable write may legally drop a request two cycles later
  assign irq_wr = io_req.wr && io_req.addr inside {8'h04, 8'h05};
  sequence wr_to(a);
    io_req.wr && io_req.addr == a;
  endsequence
  property copy(a, v, m);
    wr_to(a) |-> ##2 v == ($past(io_req.wdata, 2) & m);
  endproperty
  // a request dropped by a write shows two cycles after the strobe
  property held(b);
    b && !irq_wr && !$past(irq_wr) |=> b;
  endproperty
  dir_copy_a: assert property (copy(8'h11, pad_ctl.oe, 8'hff))
    else $error("direction copy wrong");
  data_copy_a: assert property (copy(8'h10, pad_ctl.out, 8'hff))
    else $error("data copy wrong");
  up_copy_a: assert property (copy(8'h12, pad_ctl.pull_up, 8'hff))
    else $error("pull-up copy wrong");
  dn_copy_a: assert property (copy(8'h13, pad_ctl.pull_dn, 8'hff))
    else $error("pull-down copy wrong");
  in_en_copy_a: assert property (copy(8'h0d, pad_ctl.in_en, 8'hf9))
    else $error("input enable copy wrong");
  flag0_hold_a: assert property (held(int_req_ff[0]))
    else $error("request 0 dropped");
  flag1_hold_a: assert property (held(int_req_ff[1]))
    else $error("request 1 dropped");
  sel_read_a: assert property (io_req.rd && io_req.addr == 8'h0c |=>
    io_rdata == 8'h00) else $error("edge select readable");
endmodule
bind port_a_io port_a_io_chk u_chk (.clock(clock), .rst(rst),
  .io_req(io_req), .io_rdata(io_rdata), .pad_ctl(pad_ctl),
  .int_req_ff(int_req_ff));
`default_nettype wire

// ===== sim/pin_model.sv
// board side of the port a pads
// assumes the board drives every pin the block does not drive
`timescale 1ns/100ps
`default_nettype none
module pin_model (
  // pad controls
  input  wire gpio_pkg::pad_ctl_t pad_ctl,
  // board and pin levels
  input  wire logic [7:0]         ext_lvl,
  output logic [7:0]              pin_lvl
);
  assign pin_lvl = (pad_ctl.oe & pad_ctl.out) | (~pad_ctl.oe & ext_lvl);
endmodule
`default_nettype wire

// ===== sim/port_a_io_tb_top.sv
// self-checking bench for the port a block
// assumes the pin model on the pads
`timescale 1ns/100ps
`default_nettype none
module port_a_io_tb_top;
  logic               clock, rst, pb0, pb5;
  gpio_pkg::io_req_t  io_req;
  gpio_pkg::pad_ctl_t pad;
  logic [7:0]         rdata, ext, pins, a_in, wake, v;
  logic [1:0]         irq;
  int                 n_fail, comparisons;
  port_a_io u_dut (.clock(clock), .rst(rst), .io_req(io_req),
    .io_rdata(rdata), .port_a_pin_in(pins), .port_b_pin0(pb0),
    .port_b_pin5(pb5), .pad_ctl(pad), .port_a_input(a_in),
    .wake_ff(wake), .int_req_ff(irq));
  pin_model u_pins (.pad_ctl(pad), .ext_lvl(ext), .pin_lvl(pins));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task automatic stop_test;
    if (n_fail == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(string what, logic [7:0] e, logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clock) io_req <= '{1'b1, 1'b0, a, d};
    @(posedge clock) io_req <= '0;
  endtask
  task automatic rd(logic [7:0] a);
    @(posedge clock) io_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clock) io_req <= '0;
    #1 v = rdata;
  endtask
  task automatic reg_access;
    wr(8'h11, 8'hff);
    wr(8'h10, 8'h5a);
    wr(8'h12, 8'h3c);
    wr(8'h13, 8'hc3);
    rd(8'h0c);
    chk("edge select read", 8'h00, v);
    cyc(4);
    rd(8'h10);
    chk("data", 8'h5a, v);
    rd(8'h12);
    chk("pull-up", 8'h3c, v);
    rd(8'h11);
    chk("direction", 8'hff, v);
    rd(8'h13);
    chk("pull-down", 8'hc3, v);
    rd(8'h20);
    chk("unmapped", 8'h00, v);
    wr(8'h11, 8'h00);
  endtask
  task automatic wake_case(logic [7:0] en, logic [7:0] m, logic [7:0] e);
    wr(8'h0d, en);
    cyc(2);
    v = 8'h00;
    @(posedge clock) ext <= ext ^ m;
    repeat (6) begin
      cyc(1);
      v = v | wake;
    end
    chk("wake", e, v & m);
  endtask
  task automatic irq_case(logic [7:0] s, logic [7:0] m, logic [1:0] r,
                          logic [1:0] f);
    wr(8'h0c, s);
    wr(8'h05, 8'h00);
    @(posedge clock) ext <= ext | m;
    cyc(6);
    chk("irq rise", {6'h0, r}, {6'h0, irq});
    wr(8'h05, 8'h00);
    cyc(3);
    chk("irq once", 8'h00, {6'h0, irq});
    @(posedge clock) ext <= ext & ~m;
    cyc(6);
    chk("irq fall", {6'h0, f}, {6'h0, irq});
    wr(8'h05, 8'h00);
  endtask
  task automatic pb_case;
    wr(8'h0c, 8'h05);
    wr(8'h05, 8'h00);
    @(posedge clock) pb5 <= 1'b1;
    cyc(6);
    chk("pb5 irq", 8'h01, {6'h0, irq});
    wr(8'h05, 8'h00);
    @(posedge clock) pb0 <= 1'b1;
    cyc(6);
    chk("pb0 irq", 8'h02, {6'h0, irq});
    wr(8'h05, 8'h00);
    @(posedge clock) {pb0, pb5} <= 2'h0;
    cyc(6);
    chk("pb fall", 8'h00, {6'h0, irq});
  endtask
  initial begin
    n_fail = 0;
    comparisons = 0;
    {rst, io_req, ext, pb0, pb5} = {1'b1, 18'h0, 8'h00, 2'h0};
    cyc(9);
    @(posedge clock) rst <= 1'b0;
    cyc(3);
    chk("reset in_en", 8'hf9, pad.in_en);
    chk("reset oe", 8'h00, pad.oe | pad.out);
    chk("reset pulls", 8'h00, pad.pull_up | pad.pull_dn);
    reg_access;
    wake_case(8'hf9, 8'h08, 8'h08);
    wake_case(8'hf1, 8'h08, 8'h00);
    @(posedge clock) ext <= ext | 8'h08;
    cyc(4);
    chk("gated input", 8'h00, a_in & 8'h08);
    wake_case(8'hf9, 8'he0, 8'he0);
    chk("open input", 8'h08, a_in & 8'h08);
    wake_case(8'h19, 8'he0, 8'h00);
    wr(8'h0d, 8'hf9);
    wr(8'h04, 8'h03);
    irq_case(8'h00, 8'h01, 2'h1, 2'h1);
    irq_case(8'h01, 8'h01, 2'h1, 2'h0);
    irq_case(8'h02, 8'h01, 2'h0, 2'h1);
    irq_case(8'h03, 8'h01, 2'h0, 2'h0);
    irq_case(8'h08, 8'h10, 2'h0, 2'h2);
    wr(8'h0d, 8'he9);
    irq_case(8'h00, 8'h10, 2'h0, 2'h0);
    wr(8'h0d, 8'hf8);
    irq_case(8'h00, 8'h01, 2'h0, 2'h0);
    wr(8'h0d, 8'hf9);
    pb_case;
    wr(8'h0c, 8'h01);
    @(posedge clock) ext <= 8'h01;
    cyc(6);
    wr(8'h04, 8'h00);
    cyc(3);
    chk("irq masked", 8'h00, {6'h0, irq});
    wr(8'h04, 8'h03);
    cyc(3);
    chk("irq unmasked", 8'h01, {6'h0, irq});
    stop_test;
  end
endmodule
`default_nettype wire
